// ### hw/pmc_regs.vh
// pmc_regs.vh: register offsets, field positions, reset values and timing counts
// assumes a 125 MHz pclk and a 32-bit apb register bus
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// register byte offsets
`define PMC_ACT_TMPL_ADDR 12'h000
`define PMC_ALT_TMPL_ADDR 12'h004
`define PMC_MODE_REQ_ADDR 12'h008
`define PMC_STATUS_ADDR 12'h00c
`define PMC_WAKE_EN_ADDR 12'h010
`define PMC_WAKE_SRC_ADDR 12'h014
`define PMC_BOOST_ADDR 12'h018
`define PMC_TW_PERIOD_ADDR 12'h01c

// mode request codes
`define PMC_MODE_ACTIVE 2'h0
`define PMC_MODE_ALT 2'h1
`define PMC_MODE_SLEEP 2'h2
`define PMC_MODE_HIB 2'h3

// template field: bit 0 is the processor, bit 1 is the flash
`define PMC_TMPL_CPU_BIT 0
`define PMC_TMPL_RESET 16'hffff
`define PMC_ALT_RESET 16'hfffc

// wake source bit positions
`define PMC_WK_PERIPH 0
`define PMC_WK_SUPERV 1
`define PMC_WK_TIMEWHEEL 2
`define PMC_WK_PIN 3
`define PMC_WK_EXT_RST 4
`define PMC_WK_WDOG 5
`define PMC_WK_LV_RST 6
`define PMC_WAKE_EN_RESET 7'h7f

// boost register fields
`define PMC_BOOST_VSEL_LSB 0
`define PMC_BOOST_VSEL_MSB 5
`define PMC_BOOST_STBY_BIT 8
`define PMC_BOOST_VSEL_MAX 6'h20
`define PMC_BOOST_RESET 32'h0000000f
`define PMC_BOOST_VSEL_RESET 6'h0f

// timing: sleep resume 15 us, hibernate resume under 100 us
`define PMC_CLK_MHZ 125
`define PMC_SLEEP_RESUME_US 15
`define PMC_HIB_RESUME_US 99
`define PMC_SLEEP_RESUME_CYC (`PMC_SLEEP_RESUME_US * `PMC_CLK_MHZ)
`define PMC_HIB_RESUME_CYC (`PMC_HIB_RESUME_US * `PMC_CLK_MHZ)
`define PMC_TW_PERIOD_RESET 32'h0001e848

`endif

// ### hw/pmc_power_mode_controller.v
// pmc_power_mode_controller: global power-mode controller with apb registers
// assumes wake inputs and apb signals synchronous to pclk
//
// What this block does
// - in active mode each resource follows its active template bit, writable anytime
// - disabled resource has clock gated and analog bias turned off
// - processor may disable itself; re-enabled at the next wakeup event
// - any wakeup outside hibernate returns to active and enables processor regardless of template
// - after reset the global mode is active
// - alternate active uses its own reduced template
// - leaving sleep waits 15 us resume before entering active
// - hibernate keeps configuration and sram retention asserted
// - hibernate holds gpio outputs and pin interrupt settings
// - hibernate exits only by pin interrupt, resume under 100 us
// - wakeups come from enabled interrupts or resets, all restore active outside hibernate
// - accepts peripheral, supervisor, timewheel and pin wake interrupts
// - central timewheel raises periodic wake interrupts
// - external reset pin, watchdog and precise low-voltage reset wake the chip
// - boost output selectable 1.8 V to 5.0 V in 100 mV steps
// - boost has exactly two modes, active and standby
// - boost forced active whenever chip is active or alternate active
// - sleep with boost standby wakes periodically for boost refresh
// - separate per-subsystem template registers for active and alternate active
// - entering sleep disables all resources regardless of templates
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "pmc_regs.vh"

module pmc_power_mode_controller #(
  parameter NRES = 16,
  parameter SLEEP_RESUME_CYC = `PMC_SLEEP_RESUME_CYC,
  parameter HIB_RESUME_CYC = `PMC_HIB_RESUME_CYC
) (
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // wake interrupt sources
  input wire periph_wake_irq,
  input wire supervisor_wake_irq,
  input wire pin_wake_irq,
  // reset-type wake sources
  input wire external_reset_pin,
  input wire watchdog_reset_source,
  input wire precise_low_voltage_reset,
  // resource controls
  output reg [NRES-1:0] clk_gate_en,
  output reg [NRES-1:0] bias_en,
  // retention and pin hold
  output reg sram_retain,
  output reg gpio_hold,
  // boost converter
  output reg [5:0] boost_vsel,
  output reg boost_active,
  // mode and timewheel
  output reg [1:0] global_mode,
  output reg central_timewheel
);

  localparam ST_ACTIVE = 3'h0;
  localparam ST_ALT = 3'h1;
  localparam ST_SHUT = 3'h2;
  localparam ST_SLEEP = 3'h3;
  localparam ST_HIB = 3'h4;
  localparam ST_RESUME = 3'h5;

  reg [2:0] state;
  reg [1:0] target;
  reg [17:0] cnt;
  reg [NRES-1:0] act_tmpl;
  reg [NRES-1:0] alt_tmpl;
  reg cpu_off;
  reg [6:0] wake_en;
  reg [6:0] wake_src;
  reg [5:0] vsel;
  reg boost_stby;
  reg [31:0] tw_period;
  reg [31:0] tw_cnt;
  reg tw_pulse;
  reg req_pend;
  reg [1:0] req_mode;
  reg [NRES-1:0] next_gate;
  reg [NRES-1:0] next_bias;
  reg [31:0] next_rdata;
  reg next_err;

  wire apb_wr = psel & penable & pwrite & pready;
  wire apb_rd = psel & ~penable & ~pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // per-register write strobes
  wire wr_act = apb_wr && (paddr == `PMC_ACT_TMPL_ADDR);
  wire wr_alt = apb_wr && (paddr == `PMC_ALT_TMPL_ADDR);
  wire wr_mode = apb_wr && (paddr == `PMC_MODE_REQ_ADDR);
  wire wr_wake_en = apb_wr && (paddr == `PMC_WAKE_EN_ADDR);
  wire wr_wake_src = apb_wr && (paddr == `PMC_WAKE_SRC_ADDR);
  wire wr_boost = apb_wr && (paddr == `PMC_BOOST_ADDR);
  wire wr_tw = apb_wr && (paddr == `PMC_TW_PERIOD_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // wake source vector
  wire [6:0] wake_raw;
  assign wake_raw[`PMC_WK_PERIPH] = periph_wake_irq;
  assign wake_raw[`PMC_WK_SUPERV] = supervisor_wake_irq;
  assign wake_raw[`PMC_WK_TIMEWHEEL] = tw_pulse;
  assign wake_raw[`PMC_WK_PIN] = pin_wake_irq;
  assign wake_raw[`PMC_WK_EXT_RST] = external_reset_pin;
  assign wake_raw[`PMC_WK_WDOG] = watchdog_reset_source;
  assign wake_raw[`PMC_WK_LV_RST] = precise_low_voltage_reset;
  wire [6:0] wake_hit = wake_raw & wake_en;
  wire any_wake = |wake_hit;
  wire [5:0] wr_vsel = pwdata[`PMC_BOOST_VSEL_MSB:`PMC_BOOST_VSEL_LSB];
  wire [NRES-1:0] cpu_mask = {{(NRES-1){1'b0}}, 1'b1} << `PMC_TMPL_CPU_BIT;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait state on reads, one cycle pready on writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      if (apb_rd) begin
        prdata <= next_rdata;
      end
      if (psel & ~penable) begin
        pslverr <= next_err;
      end
    end
  end

  always @* begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    if (paddr == `PMC_ACT_TMPL_ADDR) begin
      next_rdata[NRES-1:0] = act_tmpl;
    end else if (paddr == `PMC_ALT_TMPL_ADDR) begin
      next_rdata[NRES-1:0] = alt_tmpl;
    end else if (paddr == `PMC_MODE_REQ_ADDR) begin
      next_rdata[1:0] = req_mode;
    end else if (paddr == `PMC_STATUS_ADDR) begin
      next_rdata = {24'h0, cpu_off, boost_active, state, 1'b0, global_mode};
    end else if (paddr == `PMC_WAKE_EN_ADDR) begin
      next_rdata[6:0] = wake_en;
    end else if (paddr == `PMC_WAKE_SRC_ADDR) begin
      next_rdata[6:0] = wake_src;
    end else if (paddr == `PMC_BOOST_ADDR) begin
      next_rdata = {23'h0, boost_stby, 2'h0, vsel};
    end else if (paddr == `PMC_TW_PERIOD_ADDR) begin
      next_rdata = tw_period;
    end else begin
      next_err = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_tmpl <= `PMC_TMPL_RESET;
      alt_tmpl <= `PMC_ALT_RESET;
      wake_en <= `PMC_WAKE_EN_RESET;
      vsel <= `PMC_BOOST_VSEL_RESET;
      boost_stby <= 1'b0;
      tw_period <= `PMC_TW_PERIOD_RESET;
      req_pend <= 1'b0;
      req_mode <= `PMC_MODE_ACTIVE;
    end else if (clk_en) begin
      if (wr_act) begin
        act_tmpl <= pwdata[NRES-1:0];
      end
      if (wr_alt) begin
        alt_tmpl <= pwdata[NRES-1:0];
      end
      if (wr_wake_en) begin
        wake_en <= pwdata[6:0];
      end
      // clamp to 1.8..5.0 V code range
      if (wr_boost) begin
        vsel <= (wr_vsel > `PMC_BOOST_VSEL_MAX) ? `PMC_BOOST_VSEL_MAX : wr_vsel;
        boost_stby <= pwdata[`PMC_BOOST_STBY_BIT];
      end
      if (wr_tw) begin
        tw_period <= pwdata;
      end
      if (wr_mode) begin
        req_mode <= pwdata[1:0];
        req_pend <= 1'b1;
      end else if (state != ST_ACTIVE && state != ST_ALT) begin
        req_pend <= 1'b0;
      end else if (req_pend) begin
        req_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // central timewheel periodic wake pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tw_cnt <= 32'h0;
      tw_pulse <= 1'b0;
      central_timewheel <= 1'b0;
    end else if (clk_en) begin
      tw_pulse <= 1'b0;
      if (state == ST_HIB) begin
        tw_cnt <= 32'h0;
      end else if ((tw_cnt + 32'h1) >= tw_period) begin
        tw_cnt <= 32'h0;
        tw_pulse <= 1'b1;
      end else begin
        tw_cnt <= tw_cnt + 32'h1;
      end
      central_timewheel <= tw_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_ACTIVE;
      target <= `PMC_MODE_ACTIVE;
      cnt <= 18'h0;
      cpu_off <= 1'b0;
      wake_src <= 7'h0;
      global_mode <= `PMC_MODE_ACTIVE;
    end else if (clk_en) begin
      // hardware set wins over software clear
      if (wr_wake_src) begin
        wake_src <= (wake_src & ~pwdata[6:0]) | wake_hit;
      end else begin
        wake_src <= wake_src | wake_hit;
      end
      if (wr_act) begin
        cpu_off <= ~pwdata[`PMC_TMPL_CPU_BIT];
      end
      case (state)
        ST_ACTIVE, ST_ALT: begin
          // wakeup forces active and processor on
          if (any_wake) begin
            state <= ST_ACTIVE;
            global_mode <= `PMC_MODE_ACTIVE;
            cpu_off <= 1'b0;
          end else if (req_pend) begin
            if (req_mode == `PMC_MODE_ACTIVE) begin
              state <= ST_ACTIVE;
              global_mode <= `PMC_MODE_ACTIVE;
            end else if (req_mode == `PMC_MODE_ALT) begin
              state <= ST_ALT;
              global_mode <= `PMC_MODE_ALT;
            end else begin
              state <= ST_SHUT;
              target <= req_mode;
            end
          end
        end
        ST_SHUT: begin
          state <= (target == `PMC_MODE_HIB) ? ST_HIB : ST_SLEEP;
          global_mode <= target;
        end
        ST_SLEEP: begin
          // interrupt or reset wakes from sleep
          if (any_wake) begin
            state <= ST_RESUME;
            cnt <= SLEEP_RESUME_CYC[17:0] - 18'h1;
          end
        end
        ST_HIB: begin
          if (pin_wake_irq) begin
            state <= ST_RESUME;
            cnt <= HIB_RESUME_CYC[17:0] - 18'h1;
          end
        end
        ST_RESUME: begin
          if (cnt == 18'h0) begin
            state <= ST_ACTIVE;
            global_mode <= `PMC_MODE_ACTIVE;
            cpu_off <= 1'b0;
          end else begin
            cnt <= cnt - 18'h1;
          end
        end
        default: begin
          state <= ST_ACTIVE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resource enables per bit
  genvar gi;
  generate
    for (gi = 0; gi < NRES; gi = gi + 1) begin : g_res
      always @* begin
        if (state == ST_ACTIVE) begin
          next_gate[gi] = cpu_mask[gi] ? ~cpu_off : act_tmpl[gi];
        end else if (state == ST_ALT) begin
          next_gate[gi] = alt_tmpl[gi];
        end else begin
          next_gate[gi] = 1'b0;
        end
        next_bias[gi] = next_gate[gi];
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_gate_en <= `PMC_TMPL_RESET;
      bias_en <= `PMC_TMPL_RESET;
      sram_retain <= 1'b0;
      gpio_hold <= 1'b0;
      boost_vsel <= `PMC_BOOST_VSEL_RESET;
      boost_active <= 1'b1;
    end else if (clk_en) begin
      clk_gate_en <= next_gate;
      bias_en <= next_bias;
      sram_retain <= (state == ST_HIB);
      gpio_hold <= (state == ST_HIB);
      boost_vsel <= vsel;
      // boost active in active modes; active in hibernate
      // standby only while sleeping, refreshed on timewheel
      boost_active <= ~(state == ST_SLEEP && boost_stby && !tw_pulse);
    end
  end

endmodule // pmc_power_mode_controller

// ### verification/pmc_wake_model.sv
// pmc_wake_model: wake and reset-type sources beside the controller
// assumes one-cycle fire requests from the bench on pclk
`timescale 1ns/100ps
module pmc_wake_src (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // requests: periph superv pin ext wdog lowv
  input wire [5:0] fire,
  // wake lines
  output logic [5:0] wake
);
  logic [5:0] hold;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 6'h00;
      wake <= 6'h00;
    end else begin
      hold <= fire;
      wake <= fire | hold;
    end
  end
endmodule // pmc_wake_src

// ### verification/pmc_power_mode_controller_chk.sv
// pmc_power_mode_controller_chk: port assertions
// assumes a bind from the bench, one pclk domain
`timescale 1ns/100ps
module pmc_chk #(
  parameter NRES = 16,
  parameter SLEEP_RESUME_CYC = 8,
  parameter HIB_RESUME_CYC = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb answer
  input wire pready,
  // wake inputs
  input wire periph_wake_irq,
  input wire pin_wake_irq,
  // controls
  input wire [NRES-1:0] clk_gate_en,
  input wire [NRES-1:0] bias_en,
  input wire sram_retain,
  input wire gpio_hold,
  input wire [5:0] boost_vsel,
  input wire boost_active,
  input wire [1:0] global_mode
);
  logic [15:0] wcnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // cycles since a pin wake in sleep or hibernate, or a peripheral wake in sleep
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wcnt <= 16'h0000;
    else if (global_mode == 2'h0)
      wcnt <= 16'h0000;
    else if (wcnt != 16'h0000 || (global_mode[1] && pin_wake_irq)
      || (global_mode == 2'h2 && periph_wake_irq))
      wcnt <= wcnt + 16'h0001;
  end
  sequence s_back;
    global_mode == 2'h0 && $past(global_mode[1]);
  endsequence
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready held");
  property p_bias; bias_en == clk_gate_en; endproperty
  a_bias: assert property (p_bias) else $error("bias off gate");
  property p_vsel; boost_vsel <= 6'h20; endproperty
  a_vsel: assert property (p_vsel) else $error("vsel range");
  property p_boost; !global_mode[1] && !$past(global_mode[1]) |-> boost_active; endproperty
  a_boost: assert property (p_boost) else $error("boost standby");
  property p_ret; global_mode == 2'h3 && $past(global_mode) == 2'h3 && wcnt == 16'h0000
    |-> sram_retain && gpio_hold;
  endproperty
  a_ret: assert property (p_ret) else $error("no retention");
  property p_hstay; global_mode == 2'h3 && wcnt == 16'h0000 && !pin_wake_irq |=>
    global_mode == 2'h3; endproperty
  a_hstay: assert property (p_hstay) else $error("left hibernate");
  property p_rmax; wcnt <= HIB_RESUME_CYC + 8; endproperty
  a_rmax: assert property (p_rmax) else $error("resume long");
  property p_rmin; s_back |-> $past(wcnt) >= SLEEP_RESUME_CYC - 1; endproperty
  a_rmin: assert property (p_rmin) else $error("resume short");
  property p_cpu; s_back |-> ##[0:2] clk_gate_en[0]; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu off");
  property p_sleep; global_mode == 2'h2 && $past(global_mode) == 2'h2 && wcnt == 16'h0000
    |-> !clk_gate_en[0]; endproperty
  a_sleep: assert property (p_sleep) else $error("cpu on in sleep");
endmodule // pmc_chk

// ### verification/pmc_power_mode_controller_bench.sv
// pmc_power_mode_controller_bench: apb firmware and checks
// assumes pmc_regs.vh on the include path
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_power_mode_controller_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [5:0] fire = 6'h00;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, sram_retain, gpio_hold, boost_active, central_timewheel;
  logic [5:0] wk, boost_vsel;
  logic [15:0] clk_gate_en, bias_en;
  logic [1:0] global_mode;
  int fails = 0;
  int total_checks = 0;
  int n;
  logic [44:0] rows [7] = '{{`PMC_ACT_TMPL_ADDR, 32'h0000ffff, 1'b0},
    {`PMC_ALT_TMPL_ADDR, 32'h0000fffc, 1'b0}, {`PMC_WAKE_EN_ADDR, 32'h0000007f, 1'b0},
    {`PMC_BOOST_ADDR, `PMC_BOOST_RESET, 1'b0}, {`PMC_STATUS_ADDR, 32'h00000040, 1'b0},
    {`PMC_TW_PERIOD_ADDR, `PMC_TW_PERIOD_RESET, 1'b0}, {12'h020, 32'h00000000, 1'b1}};
  always #4 pclk = ~pclk;
  pmc_power_mode_controller #(.SLEEP_RESUME_CYC(8), .HIB_RESUME_CYC(16)) i_dut (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .periph_wake_irq(wk[0]), .supervisor_wake_irq(wk[1]),
    .pin_wake_irq(wk[2]), .external_reset_pin(wk[3]), .watchdog_reset_source(wk[4]),
    .precise_low_voltage_reset(wk[5]), .clk_gate_en, .bias_en, .sram_retain, .gpio_hold,
    .boost_vsel, .boost_active, .global_mode, .central_timewheel);
  pmc_wake_src i_src (.pclk, .presetn, .fire, .wake(wk));
  ////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      k++;
      if (k > 20) begin
        fails++;
        print_verdict;
      end
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task pulse(input int b);
    fire <= 6'h01 << b;
    @(posedge pclk);
    fire <= 6'h00;
  endtask
  task wmode(input logic [1:0] m);
    n = 0;
    while (global_mode !== m) begin
      @(posedge pclk);
      n++;
      if (n > 400) begin
        fails++;
        print_verdict;
      end
    end
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("mode", global_mode, 32'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, rows[i][44:33], 32'h0);
      chk("reg", q, rows[i][32:1]);
      chk("slverr", e, rows[i][0]);
    end
    $display("rows done");
    apb(1'b1, `PMC_ACT_TMPL_ADDR, 32'h00001234);
    apb(1'b0, `PMC_STATUS_ADDR, 32'h0);
    chk("cpu_off", q[7], 32'h1);
    chk("gates", clk_gate_en, 32'h1234);
    chk("bias", bias_en, 32'h1234);
    pulse(0);
    apb(1'b0, `PMC_STATUS_ADDR, 32'h0);
    chk("cpu back", clk_gate_en[0], 32'h1);
    apb(1'b1, `PMC_BOOST_ADDR, 32'h0000013f);
    apb(1'b0, `PMC_BOOST_ADDR, 32'h0);
    chk("boost reg", q, 32'h00000120);
    chk("vsel", boost_vsel, 32'h20);
    chk("boost on", boost_active, 32'h1);
    $display("template and boost done");
    for (int b = 0; b < 6; b++) begin
      apb(1'b1, `PMC_WAKE_SRC_ADDR, 32'h0000007f);
      apb(1'b1, `PMC_MODE_REQ_ADDR, 32'h1);
      wmode(2'h1);
      chk("alt gates", clk_gate_en, 32'hfffc);
      pulse(b);
      wmode(2'h0);
      apb(1'b0, `PMC_WAKE_SRC_ADDR, 32'h0);
      chk("src", q[b < 2 ? b : b + 1], 32'h1);
    end
    $display("alt wakes done");
    apb(1'b1, `PMC_WAKE_SRC_ADDR, 32'h0000007f);
    apb(1'b1, `PMC_MODE_REQ_ADDR, 32'h2);
    wmode(2'h2);
    repeat (2) @(posedge pclk);
    chk("sleep cpu", clk_gate_en[0], 32'h0);
    pulse(2);
    wmode(2'h0);
    chk("sleep resume", n >= 7, 32'h1);
    apb(1'b1, `PMC_BOOST_ADDR, 32'h00000000);
    apb(1'b1, `PMC_WAKE_SRC_ADDR, 32'h0000007f);
    apb(1'b1, `PMC_MODE_REQ_ADDR, 32'h3);
    wmode(2'h3);
    repeat (2) @(posedge pclk);
    chk("retain", {sram_retain, gpio_hold}, 32'h3);
    pulse(0);
    repeat (20) @(posedge pclk);
    chk("hib stays", global_mode, 32'h3);
    pulse(2);
    wmode(2'h0);
    chk("hib resume", n <= 30, 32'h1);
    apb(1'b0, `PMC_ACT_TMPL_ADDR, 32'h0);
    chk("kept tmpl", q[15:1], 32'h091a);
    $display("sleep and hibernate done");
    apb(1'b1, `PMC_TW_PERIOD_ADDR, 32'h00000014);
    n = 0;
    while (central_timewheel !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) begin
      @(posedge pclk);
      n = 1;
      while (central_timewheel !== 1'b1 && n < 100) begin
        @(posedge pclk);
        n++;
      end
    end
    chk("tw gap", n, 32'd20);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rst", {global_mode, clk_gate_en, boost_active}, 32'h1ffff);
    presetn <= 1'b1;
    $display("timewheel and reset done");
    print_verdict;
  end
endmodule // pmc_power_mode_controller_bench
bind pmc_power_mode_controller pmc_chk #(.NRES(NRES), .SLEEP_RESUME_CYC(SLEEP_RESUME_CYC),
  .HIB_RESUME_CYC(HIB_RESUME_CYC)) i_chk (.pclk(pclk), .presetn(presetn), .pready(pready),
  .periph_wake_irq(periph_wake_irq), .pin_wake_irq(pin_wake_irq), .clk_gate_en(clk_gate_en),
  .bias_en(bias_en), .sram_retain(sram_retain), .gpio_hold(gpio_hold),
  .boost_vsel(boost_vsel), .boost_active(boost_active), .global_mode(global_mode));
